// ===== rtl/lsd_ctrl.sv
// Low-side driver control, protection and register file
//
// Functional notes
// R1 - Over-voltage clears both low-side enable bits
// R2 - Over-voltage condition bit follows live condition
// R3 - Enabled over-voltage raises the regulator interrupt
// R4 - Reading condition bit clears pending interrupt
// R5 - New interrupt only after condition returns
// R6 - Software writes unlock key after over-voltage
// R7 - Software re-enables once condition bit reads zero
// R8 - Software trims threshold, then enables initially
// R9 - Low current sets driver open-load flag
// R10 - No open-load report while driver off
// R11 - Current-limit flag shows limitation per driver
// R12 - Over-temperature shuts drivers, latches, reports source
// R13 - Masked-in over-temperature latch drives interrupt output
// R14 - Control write re-enables after temperature clears
// R15 - Gate on only when enabled and unshut
//
// The plain strobed port and the register offsets were left to the implementer.
`timescale 1ns/10ps
module lsd_ctrl
  import lsd_pkg::*;
#(
  parameter int unsigned NUM_DRV = 2
)
(
  input  wire logic                          core_clk,
  input  wire logic                          rst,
  input  lsd_pkg::lsd_bus_req_t              bus_req,
  output logic [lsd_pkg::DATA_W-1:0]         rd_data_q,
  input  lsd_pkg::lsd_prot_in_t              prot_in,
  input  lsd_pkg::lsd_drv_in_t [NUM_DRV-1:0] drv_in,
  output logic [NUM_DRV-1:0]                 gate_q,
  output logic                               irq_q
);

  // Enable bits and shutdown state
  logic [NUM_DRV-1:0] en_q;
  logic               ov_lock_q;
  logic               ot_shut_q;
  logic               ov_prev_q;
  logic               ov_pend_q;
  logic               ov_ie_q;
  logic               ls_mask_q;
  logic [NUM_DRV-1:0] ol_flag;
  logic [NUM_DRV-1:0] cl_flag;

  // Decoded strobes
  logic               wr_ctrl;
  logic               wr_unlk;
  logic               wr_vstat;
  logic               wr_mask;
  logic               rd_vstat;
  logic               ov_rise;
  logic               shut;

  // Address decode: write strobes for four registers, one read strobe for OFS_VSTAT
  assign wr_ctrl  = bus_req.wr & (bus_req.addr == OFS_LS_CTRL);
  assign wr_unlk  = bus_req.wr & (bus_req.addr == OFS_LS_UNLK);
  assign wr_vstat = bus_req.wr & (bus_req.addr == OFS_VSTAT);
  assign wr_mask  = bus_req.wr & (bus_req.addr == OFS_IRQ_MASK);
  assign rd_vstat = bus_req.rd & (bus_req.addr == OFS_VSTAT);

  // Rising over-voltage edge and combined shutdown
  assign ov_rise  = prot_in.ov & ~ov_prev_q;
  assign shut     = prot_in.ov | ot_shut_q;

  // Previous over-voltage level for edge detection
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      ov_prev_q <= 1'b0;
    else
      ov_prev_q <= prot_in.ov;
  end

  // Over-voltage lock: armed by the event, released only by the key.
  // While the condition persists the lock keeps re-arming, so a key
  // written too early has no lasting effect.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      ov_lock_q <= 1'b0;
    else if (prot_in.ov)
      ov_lock_q <= 1'b1;  // see R1
    else if (wr_unlk && (bus_req.wdata == UNLOCK_KEY))
      ov_lock_q <= 1'b0;  // see R6
  end

  // Enable bits: forced clear during over-voltage, writable once unlocked
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      en_q <= RST_LS_CTRL[EN_LSB +: NUM_DRV];
    else if (prot_in.ov)
      en_q <= '0;  // see R1
    else if (wr_ctrl && !ov_lock_q)
      en_q <= bus_req.wdata[EN_LSB +: NUM_DRV];  // see R7, see R8
  end

  // Over-temperature shutdown latch; set wins over the clearing write
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      ot_shut_q <= 1'b0;
    else if (prot_in.ot)
      ot_shut_q <= 1'b1;  // see R12
    else if (wr_ctrl)
      ot_shut_q <= 1'b0;  // see R14
  end

  // Over-voltage interrupt pending: only a fresh edge sets it, and a
  // new edge in the clearing read cycle still wins
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      ov_pend_q <= 1'b0;
    else if (ov_rise && ov_ie_q)
      ov_pend_q <= 1'b1;  // see R3, see R5
    else if (rd_vstat)
      ov_pend_q <= 1'b0;  // see R4
  end

  // Over-voltage interrupt enable
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      ov_ie_q <= RST_OV_IE;
    else if (wr_vstat)
      ov_ie_q <= bus_req.wdata[VS_IE_BIT];
  end

  // Low-side interrupt mask
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      ls_mask_q <= RST_LS_MASK;
    else if (wr_mask)
      ls_mask_q <= bus_req.wdata[MASK_LS_BIT];
  end

  // Gate drive: enable, PWM phase and no active shutdown
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      gate_q <= '0;
    else
      gate_q <= en_q & {NUM_DRV{~shut}} & drv_phase(drv_in);  // see R15, see R12
  end

  // Interrupt request from either source
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      irq_q <= 1'b0;
    else
      irq_q <= (ot_shut_q & ls_mask_q) | ov_pend_q;  // see R13, see R3
  end

  // PWM phase of each driver gathered into one vector
  function automatic logic [NUM_DRV-1:0] drv_phase(
    input lsd_drv_in_t [NUM_DRV-1:0] d
  );
    logic [NUM_DRV-1:0] p;
    p = '0;
    for (int i = 0; i < NUM_DRV; i++)
      p[i] = d[i].pwm;
    return p;
  endfunction : drv_phase

  // Status flags per driver; judged against the driven gate so the
  // PWM off phase never reports open load
  generate
    for (genvar g = 0; g < NUM_DRV; g++)
    begin : g_flags
      lsd_drv_flags u_flags (
        .core_clk (core_clk),
        .rst      (rst),
        .drv_on   (gate_q[g]),  // see R10
        .drv_in   (drv_in[g]),
        .ol_q     (ol_flag[g]),
        .cl_q     (cl_flag[g])
      );
    end
  endgenerate

  // Read data: valid only in the cycle after the read strobe, zero
  // otherwise and for unmapped offsets
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      rd_data_q <= RST_RDATA;
    else
    begin
      rd_data_q <= '0;
      if (bus_req.rd)
      begin
        unique case (bus_req.addr)
          OFS_LS_CTRL:
            rd_data_q[EN_LSB +: NUM_DRV] <= en_q;
          OFS_LS_UNLK:
            rd_data_q[UNLK_ST_BIT] <= ov_lock_q;
          OFS_VSTAT:
          begin
            rd_data_q[VS_COND_BIT] <= prot_in.ov;  // see R2
            rd_data_q[VS_IE_BIT]   <= ov_ie_q;
          end
          OFS_LS_STAT:
          begin
            rd_data_q[OL_LSB +: NUM_DRV] <= ol_flag;  // see R9
            rd_data_q[CL_LSB +: NUM_DRV] <= cl_flag;  // see R11
          end
          OFS_IRQ_SRC:
          begin
            rd_data_q[SRC_LS_BIT] <= ot_shut_q;  // see R12
            rd_data_q[SRC_OV_BIT] <= ov_pend_q;
          end
          OFS_IRQ_MASK:
            rd_data_q[MASK_LS_BIT] <= ls_mask_q;
          default:
            rd_data_q <= '0;
        endcase
      end
    end
  end

endmodule : lsd_ctrl

// ===== rtl/lsd_pkg.sv
// Shared constants and types for the low-side driver protection block
package lsd_pkg;

  // Register bus geometry
  localparam int unsigned ADDR_W       = 4;
  localparam int unsigned DATA_W       = 8;

  // Register offsets
  localparam logic [3:0]  OFS_LS_CTRL  = 4'h0;  // low_side_control_reg
  localparam logic [3:0]  OFS_LS_UNLK  = 4'h1;  // low_side_unlock_reg
  localparam logic [3:0]  OFS_VSTAT    = 4'h2;  // voltage_status_reg
  localparam logic [3:0]  OFS_LS_STAT  = 4'h3;  // low_side_status_reg
  localparam logic [3:0]  OFS_IRQ_SRC  = 4'h4;  // interrupt_source_reg
  localparam logic [3:0]  OFS_IRQ_MASK = 4'h5;  // interrupt_mask_reg

  // Field positions
  localparam int unsigned EN_LSB       = 0;  // low_side_enable_bits in control reg
  localparam int unsigned VS_COND_BIT  = 0;  // regulator_overvoltage_condition
  localparam int unsigned VS_IE_BIT    = 7;  // regulator_overvoltage_irq_enable
  localparam int unsigned OL_LSB       = 0;  // open-load flags in status reg
  localparam int unsigned CL_LSB       = 4;  // current-limit flags in status reg
  localparam int unsigned SRC_LS_BIT   = 0;  // low-side source in source reg
  localparam int unsigned SRC_OV_BIT   = 1;  // regulator over-voltage source
  localparam int unsigned MASK_LS_BIT  = 0;  // low_side_irq_mask
  localparam int unsigned UNLK_ST_BIT  = 0;  // unlock register: still locked

  // Key that releases the over-voltage lock
  localparam logic [7:0]  UNLOCK_KEY   = 8'h05;

  // Reset values
  localparam logic [7:0]  RST_LS_CTRL  = 8'h00;
  localparam logic        RST_OV_IE    = 1'b0;
  localparam logic        RST_LS_MASK  = 1'b0;
  localparam logic [7:0]  RST_RDATA    = 8'h00;

  // Per-driver inputs from the analogue stage
  typedef struct packed {
    logic pwm;     // PWM phase, high means driver on phase
    logic ol_cmp;  // driver current below open-load threshold
    logic cl_cmp;  // driver in current limitation
  } lsd_drv_in_t;

  // Shared protection comparators
  typedef struct packed {
    logic ov;      // any regulator over-voltage present
    logic ot;      // low-side over-temperature present
  } lsd_prot_in_t;

  // Register bus request
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } lsd_bus_req_t;

endpackage : lsd_pkg

// ===== rtl/lsd_drv_flags.sv
// Per-driver open-load and current-limit status flags
`timescale 1ns/10ps
module lsd_drv_flags
  import lsd_pkg::*;
(
  input  wire logic         core_clk,
  input  wire logic         rst,
  input  wire logic         drv_on,
  input  lsd_pkg::lsd_drv_in_t drv_in,
  output logic              ol_q,
  output logic              cl_q
);

  // Open-load only judged while the driver conducts; an off driver
  // draws no current and would otherwise always look open
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      ol_q <= 1'b0;
    else
      ol_q <= drv_on & drv_in.ol_cmp;  // see R9, see R10
  end

  // Current limitation follows the comparator while the stage is driven
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      cl_q <= 1'b0;
    else
      cl_q <= drv_on & drv_in.cl_cmp;  // see R11
  end

endmodule : lsd_drv_flags

// ===== dv/lsd_ctrl_props.sv
// Port-level assertions for the low-side control block
`timescale 1ns/10ps
module lsd_ctrl_props
  import lsd_pkg::*;
#(parameter int unsigned NUM_DRV = 2)
(
  input wire logic                          core_clk,
  input wire logic                          rst,
  input lsd_pkg::lsd_bus_req_t              bus_req,
  input wire logic [lsd_pkg::DATA_W-1:0]    rd_data_q,
  input lsd_pkg::lsd_prot_in_t              prot_in,
  input lsd_pkg::lsd_drv_in_t [NUM_DRV-1:0] drv_in,
  input wire logic [NUM_DRV-1:0]            gate_q,
  input wire logic                          irq_q
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // Shutdown must not wait for software
  ov_shut_a: assert property (prot_in.ov |=> gate_q == '0)
    else $error("gate on in over-voltage");
  ot_shut_a: assert property (prot_in.ot |=> ##1 gate_q == '0)
    else $error("gate on in over-temperature");
  gate_pwm_a: assert property (gate_q[0] |-> $past(drv_in[0].pwm))
    else $error("gate on in pwm off phase");
  // Read port answers once, then idles at zero
  vs_read_a: assert property (bus_req.rd && bus_req.addr == OFS_VSTAT
    |=> rd_data_q[VS_COND_BIT] == $past(prot_in.ov)) else $error("stale ov bit");
  rd_idle_a: assert property (!bus_req.rd |=> rd_data_q == 8'h00)
    else $error("read data not idle");
  // An interrupt edge always has a cause two edges back, or a write one edge back
  irq_rise_a: assert property ($rose(irq_q) |-> $past(prot_in.ot, 2)
    || $past(prot_in.ov, 2) || $past(bus_req.wr, 2) || $past(bus_req.wr))
    else $error("irq without cause");
  irq_fall_a: assert property ($fell(irq_q) |-> $past(bus_req.rd, 2)
    || $past(bus_req.wr, 2) || $past(bus_req.wr)) else $error("irq dropped alone");
  reset_quiet_a: assert property ($fell(rst) |-> gate_q == '0 && !irq_q)
    else $error("outputs active after reset");
endmodule : lsd_ctrl_props

bind lsd_ctrl lsd_ctrl_props #(.NUM_DRV(NUM_DRV)) u_lsd_ctrl_props (.core_clk, .rst,
  .bus_req, .rd_data_q, .prot_in, .drv_in, .gate_q, .irq_q);

// ===== dv/lsd_analog_model.sv
// Behavioural model of the driver stages and protection comparators
`timescale 1ns/10ps
module lsd_analog_model
  import lsd_pkg::*;
(
  input wire logic          core_clk,
  input wire logic [1:0]    gate_q,
  input wire logic          pwm_on,
  input wire logic          ov_req,
  input wire logic          ot_req,
  output lsd_pkg::lsd_prot_in_t      prot_in,
  output lsd_pkg::lsd_drv_in_t [1:0] drv_in
);
  localparam logic [1:0] OPEN_LD  = 2'b01;  // Driver 0 has no load
  localparam logic [1:0] SHORT_LD = 2'b10;  // Driver 1 is shorted
  // An off driver draws no current, so its comparator reads open load
  always @(posedge core_clk)
  begin
    prot_in <= '{ov_req, ot_req};
    for (int i = 0; i < 2; i++)
      drv_in[i] <= '{pwm_on, OPEN_LD[i] | ~gate_q[i], SHORT_LD[i] & gate_q[i]};
  end
endmodule : lsd_analog_model

// ===== dv/lsd_ctrl_test.sv
// Directed register-level test of the low-side control block
`timescale 1ns/10ps
module lsd_ctrl_test;
  import lsd_pkg::*;
  logic              core_clk, rst, irq_q, pwm_on, ov_req, ot_req;
  lsd_bus_req_t      bus_req;
  lsd_prot_in_t      prot_in;
  lsd_drv_in_t [1:0] drv_in;
  logic [7:0]        rd_data_q;
  logic [1:0]        gate_q;
  int                mismatches, compares;

  lsd_ctrl #(.NUM_DRV(2)) u_lsd_ctrl (.core_clk, .rst, .bus_req, .rd_data_q, .prot_in,
    .drv_in, .gate_q, .irq_q);
  lsd_analog_model u_lsd_analog_model (.core_clk, .gate_q, .pwm_on, .ov_req, .ot_req,
    .prot_in, .drv_in);

  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    compares++;
    if (g !== e)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // Strobes last one cycle; the gap cycle keeps drivers from colliding
  task automatic wr(logic [3:0] a, logic [7:0] d);
    @(posedge core_clk) bus_req <= '{a, d, 1'b1, 1'b0};
    @(posedge core_clk) bus_req <= '0;
  endtask : wr
  task automatic rd(logic [3:0] a, logic [7:0] e);
    @(posedge core_clk) bus_req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge core_clk) bus_req <= '0;
    #1 chk($sformatf("reg %h", a), e, rd_data_q);
  endtask : rd
  task automatic pins(int n, logic [1:0] g, logic i);
    repeat (n) @(posedge core_clk);
    #1 chk("gate", {6'h0, g}, {6'h0, gate_q});
    chk("irq", {7'h0, i}, {7'h0, irq_q});
  endtask : pins
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : give_verdict

  initial
  begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  // Watchdog, far beyond the directed run
  initial
  begin
    repeat (3000) @(posedge core_clk);
    mismatches++;
    give_verdict();
  end
  initial
  begin
    {rst, pwm_on, ov_req, ot_req} = 4'b1100;
    bus_req = '0;
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    rd(OFS_LS_CTRL, RST_LS_CTRL);
    rd(OFS_VSTAT, 8'h00);
    wr(4'hf, 8'hff);
    rd(4'hf, RST_RDATA);
    $display("reset test done");
    wr(OFS_LS_CTRL, 8'h03);
    pins(3, 2'b11, 1'b0);
    rd(OFS_LS_STAT, 8'h21);
    @(posedge core_clk) pwm_on <= 1'b0;
    pins(3, 2'b00, 1'b0);
    rd(OFS_LS_STAT, 8'h00);
    @(posedge core_clk) pwm_on <= 1'b1;
    $display("flag test done");
    @(posedge core_clk) ov_req <= 1'b1;
    pins(4, 2'b00, 1'b0);
    @(posedge core_clk) ov_req <= 1'b0;
    wr(OFS_LS_UNLK, UNLOCK_KEY);
    wr(OFS_LS_CTRL, 8'h03);
    wr(OFS_VSTAT, 8'h80);
    @(posedge core_clk) ov_req <= 1'b1;
    pins(4, 2'b00, 1'b1);
    rd(OFS_VSTAT, 8'h81);
    wr(OFS_LS_CTRL, 8'h03);
    pins(4, 2'b00, 1'b0);
    rd(OFS_LS_CTRL, 8'h00);
    @(posedge core_clk) ov_req <= 1'b0;
    wr(OFS_LS_CTRL, 8'h03);
    rd(OFS_LS_CTRL, 8'h00);
    rd(OFS_LS_UNLK, 8'h01);
    wr(OFS_LS_UNLK, UNLOCK_KEY);
    rd(OFS_VSTAT, 8'h80);
    wr(OFS_LS_CTRL, 8'h03);
    pins(3, 2'b11, 1'b0);
    @(posedge core_clk) ov_req <= 1'b1;
    pins(4, 2'b00, 1'b1);
    rd(OFS_IRQ_SRC, 8'h02);
    rd(OFS_VSTAT, 8'h81);
    @(posedge core_clk) ov_req <= 1'b0;
    wr(OFS_LS_UNLK, UNLOCK_KEY);
    wr(OFS_LS_CTRL, 8'h03);
    $display("overvoltage test done");
    wr(OFS_IRQ_MASK, 8'h01);
    rd(OFS_IRQ_MASK, 8'h01);
    @(posedge core_clk) ot_req <= 1'b1;
    pins(4, 2'b00, 1'b1);
    rd(OFS_IRQ_SRC, 8'h01);
    wr(OFS_LS_CTRL, 8'h03);
    pins(3, 2'b00, 1'b1);
    @(posedge core_clk) ot_req <= 1'b0;
    wr(OFS_LS_CTRL, 8'h03);
    pins(3, 2'b11, 1'b0);
    rd(OFS_IRQ_SRC, 8'h00);
    $display("overtemp test done");
    give_verdict();
  end
endmodule : lsd_ctrl_test
